/* hdl/trap_unit_defines.svh */
`ifndef TRAP_UNIT_DEFINES_SVH
`define TRAP_UNIT_DEFINES_SVH

// register port offsets
`define OFS_TRAP_FLAG 8'h00
`define OFS_TRAP_MASK 8'h01
`define OFS_VEC_SEGMENT 8'h02
`define OFS_VEC_SPACING 8'h03
`define OFS_TRAP_STATUS 8'h04

// widths
`define NUM_COND 9
`define NUM_CLASS_A 4
`define REG_W 16
`define ADDR_W 8

// condition bit positions in the flag register
`define BIT_SYSREQ0 0
`define BIT_STACK_OVER 1
`define BIT_STACK_UNDER 2
`define BIT_SOFT_BREAK 3
`define BIT_SYSREQ1 4
`define BIT_BAD_OPCODE 5
`define BIT_ACCESS_ERR 6
`define BIT_PROT_FAULT 7
`define BIT_WORD_OPERAND 8
`define CLASS_A_LO 0
`define CLASS_A_HI 3
`define CLASS_B_LO 4
`define CLASS_B_HI 8

// trap numbers
`define TNUM_RESET 7'h00
`define TNUM_SYSREQ0 7'h02
`define TNUM_STACK_OVER 7'h04
`define TNUM_STACK_UNDER 7'h06
`define TNUM_SOFT_BREAK 7'h08
`define TNUM_CLASS_B 7'h0A

// vector arithmetic
`define SPACING_BASE_SHIFT 5'h02
`define SPACING_RESET 2'h0
`define SEGMENT_RESET 8'h00
`define MASK_RESET 9'h000
`define VEC_OFS_CLASS_B 16'h0028

`endif

/* hdl/trap_unit_pkg.sv */
`include "trap_unit_defines.svh"

package trap_unit_pkg;

  // service level of the trap currently running
  typedef enum logic [1:0] {
    LVL_NONE = 2'b00,
    LVL_B = 2'b01,
    LVL_A = 2'b10
  } level_t;

  typedef struct packed {
    logic [`NUM_COND-1:0] flags;
    logic [`NUM_COND-1:0] mask;
    logic [`NUM_COND-1:0] pend;
    logic [7:0] vector_segment_select;
    logic [1:0] spacing;
    level_t act;
    level_t sav;
    logic [`REG_W-1:0] rdata;
    logic boot;
    logic branchValid;
    logic [23:0] branchAddr;
    logic [6:0] branchNum;
  } trap_state_t;

endpackage

/* hdl/vector_address_calc.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trap_unit_defines.svh"

module vector_address_calc (
  // vector table placement
  input wire logic [7:0] vecSegment,
  input wire logic [1:0] vecSpacing,
  // selected trap number
  input wire logic [6:0] trapNum,
  // full branch target
  output logic [23:0] vecAddr
);

  logic [4:0] shiftAmt;
  logic [15:0] offset;

  // spacing field 0 gives 4-byte steps, each step doubles it
  assign shiftAmt = `SPACING_BASE_SHIFT + {3'h0, vecSpacing};
  assign offset = 16'({9'h000, trapNum} << shiftAmt);
  assign vecAddr = {vecSegment, offset};

endmodule // vector_address_calc

`default_nettype wire

/* hdl/hardware_trap_unit.sv */
`timescale 1ns/1ps
`default_nettype none
`include "trap_unit_defines.svh"

module hardware_trap_unit
  import trap_unit_pkg::*;
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // register port
  input wire logic [`ADDR_W-1:0] regAddr,
  input wire logic [`REG_W-1:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [`REG_W-1:0] regRdata,
  // trap conditions, one-cycle pulses
  input wire logic [`NUM_COND-1:0] trapCond,
  // software trap instruction
  input wire logic swTrapReq,
  input wire logic [6:0] swTrapNum,
  output logic swTrapAck,
  // end of a trap service routine
  input wire logic trapReturn,
  // branch to program flow
  output logic branchValid,
  output logic [23:0] branchAddr,
  output logic [6:0] branchTrapNum,
  // towards interrupt controller
  output logic blockIntPec,
  output logic [1:0] activeLevel,
  output logic irq
);

  trap_state_t s_ff;
  trap_state_t nxt_s;
  logic [6:0] selNum;
  logic [23:0] selAddr;
  level_t effAct;
  level_t effSav;
  logic flagClr;
  logic [`NUM_COND-1:0] allPend;
  logic [`NUM_CLASS_A-1:0] pendA;
  logic [1:0] idxA;

  // lowest index wins: lower numbers rank higher within class A
  function automatic logic [1:0] first_set(input logic [`NUM_CLASS_A-1:0] vec);
    logic [1:0] idx;
    idx = 2'h0;
    for (int i = `NUM_CLASS_A - 1; i >= 0; i--) begin
      if (vec[i]) begin
        idx = 2'(i);
      end
    end
    return idx;
  endfunction

  function automatic logic [6:0] class_a_num(input logic [1:0] idx);
    logic [6:0] num;
    case (idx)
      2'h0: num = `TNUM_SYSREQ0;
      2'h1: num = `TNUM_STACK_OVER;
      2'h2: num = `TNUM_STACK_UNDER;
      2'h3: num = `TNUM_SOFT_BREAK;
      default: num = `TNUM_SYSREQ0;
    endcase
    return num;
  endfunction

  vector_address_calc u_vec (
    .vecSegment(s_ff.vector_segment_select),
    .vecSpacing(s_ff.spacing),
    .trapNum(selNum),
    .vecAddr(selAddr)
  );

  always_comb begin
    nxt_s = s_ff;
    nxt_s.branchValid = 1'b0;
    nxt_s.rdata = '0;
    selNum = `TNUM_RESET;
    swTrapAck = 1'b0;
    flagClr = regRd && (regAddr == `OFS_TRAP_FLAG);

    // register reads, data shown in the next cycle only
    if (regRd) begin
      case (regAddr)
        `OFS_TRAP_FLAG: nxt_s.rdata = {7'h00, s_ff.flags};
        `OFS_TRAP_MASK: nxt_s.rdata = {7'h00, s_ff.mask};
        `OFS_VEC_SEGMENT: nxt_s.rdata = {8'h00, s_ff.vector_segment_select};
        `OFS_VEC_SPACING: nxt_s.rdata = {14'h0000, s_ff.spacing};
        `OFS_TRAP_STATUS: nxt_s.rdata = {3'h0, s_ff.pend, s_ff.sav, s_ff.act};
        default: nxt_s.rdata = '0;
      endcase
    end

    if (regWr) begin
      case (regAddr)
        `OFS_TRAP_MASK: nxt_s.mask = regWdata[`NUM_COND-1:0];
        `OFS_VEC_SEGMENT: nxt_s.vector_segment_select = regWdata[7:0];
        `OFS_VEC_SPACING: nxt_s.spacing = regWdata[1:0];
        default: nxt_s.mask = s_ff.mask;
      endcase
    end

    // a new occurrence beats a read-clear in the same cycle
    nxt_s.flags = (flagClr ? '0 : s_ff.flags) | trapCond;

    // return first, so a waiting trap can start in the same cycle
    effAct = s_ff.act;
    effSav = s_ff.sav;
    if (trapReturn && s_ff.act != LVL_NONE) begin
      effAct = s_ff.sav;
      effSav = LVL_NONE;
    end
    nxt_s.act = effAct;
    nxt_s.sav = effSav;

    allPend = s_ff.pend | trapCond;
    pendA = allPend[`CLASS_A_HI:`CLASS_A_LO];
    idxA = first_set(pendA);
    nxt_s.pend = allPend;

    if (s_ff.boot) begin
      // reset branches to offset zero of the vector segment
      selNum = `TNUM_RESET;
      nxt_s.boot = 1'b0;
      nxt_s.branchValid = 1'b1;
    end else if (|pendA && effAct != LVL_A) begin
      // class A preempts the program and any class B service
      selNum = class_a_num(idxA);
      nxt_s.pend[idxA] = 1'b0;
      nxt_s.sav = effAct;
      nxt_s.act = LVL_A;
      nxt_s.branchValid = 1'b1;
    end else if (|allPend[`CLASS_B_HI:`CLASS_B_LO] && effAct == LVL_NONE) begin
      // shared vector: all waiting class B causes are served at once
      selNum = `TNUM_CLASS_B;
      nxt_s.pend[`CLASS_B_HI:`CLASS_B_LO] = '0;
      nxt_s.act = LVL_B;
      nxt_s.branchValid = 1'b1;
    end else if (swTrapReq) begin
      // software trap keeps the current level and leaves flags alone
      selNum = swTrapNum;
      swTrapAck = 1'b1;
      nxt_s.branchValid = 1'b1;
    end
    nxt_s.branchNum = selNum;
    nxt_s.branchAddr = nxt_s.branchValid ? selAddr : s_ff.branchAddr;
  end

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      s_ff <= '{flags: '0, mask: `MASK_RESET, pend: '0, vector_segment_select: `SEGMENT_RESET,
                spacing: `SPACING_RESET, act: LVL_NONE, sav: LVL_NONE, rdata: '0,
                boot: 1'b1, branchValid: 1'b0, branchAddr: 24'h00_0000,
                branchNum: `TNUM_RESET};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign regRdata = s_ff.rdata;
  assign branchValid = s_ff.branchValid;
  assign branchAddr = s_ff.branchAddr;
  assign branchTrapNum = s_ff.branchNum;
  assign activeLevel = s_ff.act;
  // mask only gates the interrupt line, never the trap branch itself
  assign irq = |(s_ff.flags & s_ff.mask);
  assign blockIntPec = (s_ff.act != LVL_NONE);

  // checks
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_b);

  property p_class_a_at_once;
    (|trapCond[`CLASS_A_HI:`CLASS_A_LO] && s_ff.act != LVL_A && !s_ff.boot)
      |=> (branchValid && branchTrapNum inside {`TNUM_SYSREQ0, `TNUM_STACK_OVER,
                                                 `TNUM_STACK_UNDER, `TNUM_SOFT_BREAK});
  endproperty
  a_class_a_at_once: assert property (p_class_a_at_once)
    else $error("class A condition did not branch next cycle");

  property p_flag_set;
    (trapCond != '0) |=> ((s_ff.flags & $past(trapCond)) == $past(trapCond));
  endproperty
  a_flag_set: assert property (p_flag_set)
    else $error("trap occurrence did not set its flag");

  property p_b_waits;
    (s_ff.act == LVL_A && !trapReturn) |=> !(branchValid && branchTrapNum == `TNUM_CLASS_B);
  endproperty
  a_b_waits: assert property (p_b_waits)
    else $error("class B branched during class A service");

  property p_nest_restore;
    (s_ff.act == LVL_A && s_ff.sav == LVL_B && trapReturn && trapCond == '0
      && s_ff.pend[`CLASS_A_HI:`CLASS_A_LO] == '0)
      |=> (activeLevel == LVL_B) ##1 (activeLevel == LVL_B || $past(trapReturn)
      || $past(trapCond[`CLASS_A_HI:`CLASS_A_LO]) != '0);
  endproperty
  a_nest_restore: assert property (p_nest_restore)
    else $error("return from nested trap did not restore class B level");

  property p_block_after_hw;
    (branchValid && branchTrapNum != `TNUM_RESET && !$past(swTrapAck)) |-> blockIntPec;
  endproperty
  a_block_after_hw: assert property (p_block_after_hw)
    else $error("interrupts not blocked during trap service");

  property p_class_b_vector;
    (branchValid && branchTrapNum == `TNUM_CLASS_B && $past(s_ff.spacing) == `SPACING_RESET
      && !$past(swTrapAck))
      |-> (branchAddr[15:0] == `VEC_OFS_CLASS_B && activeLevel == LVL_B);
  endproperty
  a_class_b_vector: assert property (p_class_b_vector)
    else $error("class B branch used wrong vector");

  property p_segment;
    branchValid |-> (branchAddr[23:16] == $past(s_ff.vector_segment_select)
      && branchAddr[15:0] == 16'({9'h000, branchTrapNum}
      << (`SPACING_BASE_SHIFT + $past(s_ff.spacing))));
  endproperty
  a_segment: assert property (p_segment)
    else $error("vector address not built from segment and spacing");

  property p_sw_keeps_level;
    (swTrapAck && !trapReturn) |=> (branchValid && branchTrapNum == $past(swTrapNum)
      && activeLevel == $past(activeLevel));
  endproperty
  a_sw_keeps_level: assert property (p_sw_keeps_level)
    else $error("software trap changed level or number");

  property p_sw_no_flag;
    (swTrapAck && trapCond == '0 && !flagClr) |=> (s_ff.flags == $past(s_ff.flags));
  endproperty
  a_sw_no_flag: assert property (p_sw_no_flag)
    else $error("software trap touched the flags");

  property p_read_clear;
    (flagClr && trapCond == '0) |=> (s_ff.flags == '0 && !irq);
  endproperty
  a_read_clear: assert property (p_read_clear)
    else $error("flag read did not clear the flags");

  c_class_a: cover property (branchValid && branchTrapNum == `TNUM_STACK_OVER);
  c_class_b: cover property (branchValid && branchTrapNum == `TNUM_CLASS_B);
  c_nested: cover property (s_ff.act == LVL_A && s_ff.sav == LVL_B);
  c_sw_trap: cover property (swTrapAck ##1 branchValid);

endmodule // hardware_trap_unit

`default_nettype wire

/* testbench/cpu_flow_model.sv */
`timescale 1ns/1ps
`default_nettype none

module cpu_flow_model (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // branches seen from the trap unit
  input wire logic branchValid,
  input wire logic [6:0] branchTrapNum,
  // service length in cycles
  input wire logic [7:0] svcLen,
  // end of service
  output logic trapReturn
);
  logic [3:0] openSvc;
  logic [7:0] tmr;
  logic isHw;
  // only hardware vectors open a service; software traps never return
  assign isHw = branchValid && (branchTrapNum inside {7'h02, 7'h04, 7'h06, 7'h08, 7'h0A});
  // one return pulse per open service, innermost first
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      openSvc <= 4'h0;
      tmr <= 8'h00;
      trapReturn <= 1'b0;
    end else if (openSvc != 4'h0 && tmr >= svcLen) begin
      trapReturn <= 1'b1;
      tmr <= 8'h00;
      openSvc <= openSvc - 4'h1 + {3'h0, isHw};
    end else begin
      trapReturn <= 1'b0;
      tmr <= (openSvc != 4'h0) ? tmr + 8'h01 : 8'h00;
      openSvc <= openSvc + {3'h0, isHw};
    end
  end
endmodule // cpu_flow_model

`default_nettype wire

/* testbench/hardware_trap_unit_tb.sv */
`timescale 1ns/1ps
`default_nettype none

module hardware_trap_unit_tb;
  import trap_unit_pkg::*;
  logic core_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] regAddr = 8'h00;
  logic [15:0] regWdata = 16'h0000;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic [15:0] regRdata;
  logic [8:0] trapCond = 9'h000;
  logic swTrapReq = 1'b0;
  logic [6:0] swTrapNum = 7'h00;
  logic swTrapAck;
  logic trapReturn;
  logic branchValid;
  logic [23:0] branchAddr;
  logic [6:0] branchTrapNum;
  logic blockIntPec;
  logic [1:0] activeLevel;
  logic irq;
  logic [7:0] svcLen = 8'h04;
  logic [15:0] rd;
  int num_errors = 0;
  int total_checks = 0;
  int waited;

  always #2.5 core_clk = ~core_clk;

  hardware_trap_unit DUT (.core_clk(core_clk), .rst_b(rst_b), .regAddr(regAddr),
    .regWdata(regWdata), .regWr(regWr), .regRd(regRd), .regRdata(regRdata),
    .trapCond(trapCond), .swTrapReq(swTrapReq), .swTrapNum(swTrapNum),
    .swTrapAck(swTrapAck), .trapReturn(trapReturn), .branchValid(branchValid),
    .branchAddr(branchAddr), .branchTrapNum(branchTrapNum), .blockIntPec(blockIntPec),
    .activeLevel(activeLevel), .irq(irq));

  cpu_flow_model u_cpu (.core_clk(core_clk), .rst_b(rst_b), .branchValid(branchValid),
    .branchTrapNum(branchTrapNum), .svcLen(svcLen), .trapReturn(trapReturn));

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    total_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge core_clk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge core_clk);
    regWr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rdr(input logic [7:0] a);
    @(posedge core_clk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge core_clk);
    regRd <= 1'b0;
    #1;
    rd = regRdata;
  endtask

  task automatic pulse(input int b);
    @(posedge core_clk);
    trapCond <= 9'h001 << b;
    @(posedge core_clk);
    trapCond <= 9'h000;
  endtask

  task automatic waitBr();
    waited = 0;
    #1;
    while (branchValid !== 1'b1) begin
      if (waited == 80) begin
        num_errors++;
        stop_test();
      end
      @(posedge core_clk);
      #1;
      waited++;
    end
  endtask

  task automatic waitIdle();
    // sample after the edge so the level is settled
    for (int i = 0; i < 100 && activeLevel !== 2'b00; i++) begin
      @(posedge core_clk);
      #1;
    end
    chk(activeLevel, 2'b00);
    if (activeLevel !== 2'b00) begin
      stop_test();
    end
  endtask

  // hardware trap of condition b: number n, level lv
  task automatic trapChk(input int b, input logic [6:0] n, input logic [23:0] a,
                         input logic [1:0] lv);
    pulse(b);
    waitBr();
    chk(waited, 0);
    chk(branchTrapNum, n);
    chk(branchAddr, a);
    chk(activeLevel, lv);
    chk(blockIntPec, 1'b1);
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rst_b <= 1'b1;
    waitBr();
    chk(branchTrapNum, 7'h00);
    chk(branchAddr, 24'h00_0000);
    $display("test reset vector done");
    wr(8'h01, 16'h01FF);
    rdr(8'h01);
    chk(rd, 16'h01FF);
    rdr(8'h07);
    chk(rd, 16'h0000);
    for (int b = 0; b < 4; b++) begin
      trapChk(b, 7'(2 * b + 2), {8'h00, 16'(8 * b + 8)}, LVL_A);
      waitIdle();
      chk(blockIntPec, 1'b0);
    end
    chk(irq, 1'b1);
    rdr(8'h00);
    chk(rd, 16'h000F);
    chk(irq, 1'b0);
    $display("test class a done");
    for (int b = 4; b < 9; b++) begin
      trapChk(b, 7'h0A, 24'h00_0028, LVL_B);
      waitIdle();
    end
    rdr(8'h00);
    chk(rd, 16'h01F0);
    rdr(8'h00);
    chk(rd, 16'h0000);
    $display("test class b done");
    svcLen <= 8'h0A;
    trapChk(5, 7'h0A, 24'h00_0028, LVL_B);
    trapChk(0, 7'h02, 24'h00_0008, LVL_A);
    pulse(6);
    waitBr();
    chk(waited > 2, 1'b1);
    chk(branchTrapNum, 7'h0A);
    waitIdle();
    rdr(8'h00);
    chk(rd, 16'h0061);
    $display("test preemption done");
    svcLen <= 8'h04;
    wr(8'h02, 16'h0012);
    wr(8'h03, 16'h0001);
    trapChk(2, 7'h06, 24'h12_0030, LVL_A);
    waitIdle();
    rdr(8'h00);
    chk(rd, 16'h0004);
    wr(8'h03, 16'h0000);
    $display("test vector placement done");
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      swTrapReq <= 1'b1;
      swTrapNum <= (i == 0) ? 7'h7F : 7'h00;
      #1;
      chk(swTrapAck, 1'b1);
      @(posedge core_clk);
      swTrapReq <= 1'b0;
      #1;
      chk(branchValid, 1'b1);
      chk(branchAddr, (i == 0) ? 24'h12_01FC : 24'h12_0000);
      chk(activeLevel, 2'b00);
    end
    rdr(8'h00);
    chk(rd, 16'h0000);
    $display("test software trap done");
    stop_test();
  end
endmodule // hardware_trap_unit_tb

`default_nettype wire
